// ---- inc/sejc_map.svh ----
// Constants for the servo enable and jog control block.
// Assumes a 100 MHz aclk and an AXI4-Lite register port.
//
// Behaviour
// - After reset show reset, then not-ready, then ready, then await enable.
// - Input mapped to function 1 is servo enable; active powers motor.
// - Panel jog refused while servo enable is active.
// - Jog speed from setpoint, 0 to 6000 rpm, default 100, immediate.
// - Panel jog entry selects jog mode and shows default setpoint.
// - In jog mode up/down adjust speed; set enters jogging, shows jog.
// - Jogging: hold up forward, hold down reverse; release stops at once.
// - Mode key leaves jog; adjusted speed discarded, stored default restored.
// - Input jog works in every control mode.
// - Forward jog input active drives forward at jog speed; inactive stops.
// - Reverse jog input active drives reverse at jog speed; inactive stops.
// - Enable falling while below stationary threshold drops brake same time.
`ifndef SEJC_MAP_SVH
`define SEJC_MAP_SVH
`define SEJC_OFF_CTRL      8'h00
`define SEJC_OFF_SPEED     8'h04
`define SEJC_OFF_THRESH    8'h08
`define SEJC_OFF_FUNSEL    8'h0C
`define SEJC_OFF_STATUS    8'h10
`define SEJC_OFF_CMD       8'h14
`define SEJC_SPEED_MAX     16'h1770
`define SEJC_SPEED_DEF     16'h0064
`define SEJC_THRESH_DEF    16'h001E
`define SEJC_FUN_ENABLE    8'h01
`define SEJC_FUN_FWD       8'h12
`define SEJC_FUN_REV       8'h13
`define SEJC_STEP_MS       16'h0001
`define SEJC_NRD_CYC       16'h0064
`define SEJC_RST_CYC       16'h0064
`define SEJC_RESP_OKAY     2'b00
`define SEJC_RESP_SLVERR   2'b10
`endif

// ---- inc/sejc_pkg.sv ----
// Types for the servo enable and jog control block.
// Assumes sejc_map.svh supplies the numeric constants.
package sejc_pkg;
   typedef enum logic [5:0] {
      SEJC_RESET = 6'b000001,
      SEJC_NRD   = 6'b000010,
      SEJC_RDY   = 6'b000100,
      SEJC_RUN   = 6'b001000,
      SEJC_JMODE = 6'b010000,
      SEJC_JOG   = 6'b100000
   } sejc_state_t;

   typedef enum logic [1:0] {
      SEJC_DISP_BOOT = 2'b00,
      SEJC_DISP_NRD  = 2'b01,
      SEJC_DISP_RDY  = 2'b10,
      SEJC_DISP_JOG  = 2'b11
   } sejc_disp_t;
endpackage

// ---- rtl/sejc_top.sv ----
// Servo enable, readiness sequence and jog control with AXI4-Lite registers.
// Assumes di pins and panel keys are asynchronous and synchronised here.
`timescale 1ns/1ns
`include "sejc_map.svh"
module sejc_top
   import sejc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  di_pins,
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic        key_set,
   input  wire logic        key_mode,
   input  wire logic [15:0] motor_speed,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             motor_power,
   output logic             brake_release,
   output logic             run_fwd,
   output logic             run_rev,
   output logic [15:0]      speed_cmd,
   output logic [1:0]       disp_code
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic [7:0]  prev;
      sejc_state_t st;
      logic [15:0] cnt;
      logic        ready;
      logic [15:0] speed_set;
      logic [15:0] speed_jog;
      logic [15:0] thresh;
      logic [7:0]  fun0;
      logic [7:0]  fun1;
      logic [7:0]  fun2;
      logic [7:0]  fun3;
      logic        entry_req;
      logic        refused;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        power;
      logic        brake;
      logic        fwd;
      logic        rev;
      logic [15:0] spd;
      sejc_disp_t  disp;
   } sejc_regs_t;

   sejc_regs_t r;
   sejc_regs_t next_r;

   // Input mapped to a given function, per DI function code
   function automatic logic di_fn(input logic [7:0] code, input sejc_regs_t q);
      di_fn = (q.fun0 == code && q.s2[0]) || (q.fun1 == code && q.s2[1]) ||
              (q.fun2 == code && q.s2[2]) || (q.fun3 == code && q.s2[3]);
   endfunction

   function automatic logic [15:0] clamp_spd(input logic [15:0] v);
      clamp_spd = (v > `SEJC_SPEED_MAX) ? `SEJC_SPEED_MAX : v;
   endfunction

   logic        sv_en;
   logic        jf;
   logic        jr;
   logic        rise_up;
   logic        rise_dn;
   logic        rise_set;
   logic        rise_mode;
   logic        wr_fire;
   logic [31:0] wr_val;

   assign sv_en     = di_fn(`SEJC_FUN_ENABLE, r);
   assign jf        = di_fn(`SEJC_FUN_FWD, r);
   assign jr        = di_fn(`SEJC_FUN_REV, r);
   assign rise_up   = r.s2[4] & ~r.prev[4];
   assign rise_dn   = r.s2[5] & ~r.prev[5];
   assign rise_set  = r.s2[6] & ~r.prev[6];
   assign rise_mode = r.s2[7] & ~r.prev[7];
   assign wr_fire   = r.aw_got & r.w_got & ~r.bvalid;
   assign wr_val    = {{8{r.w_strb[3]}}, {8{r.w_strb[2]}}, {8{r.w_strb[1]}},
                       {8{r.w_strb[0]}}} & r.w_data;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_r = r;
      next_r.s1   = {key_mode, key_set, key_down, key_up, di_pins};
      next_r.s2   = r.s1;
      next_r.prev = r.s2;
      next_r.awready = 1'b0;
      next_r.wready  = 1'b0;
      next_r.arready = 1'b0;

      // Write channel, address and data in either order
      if (s_axi_awvalid && !r.aw_got && !r.awready) begin
         next_r.awready = 1'b1;
         next_r.aw_got  = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got && !r.wready) begin
         next_r.wready = 1'b1;
         next_r.w_got  = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_r.bvalid = 1'b1;
         next_r.bresp  = `SEJC_RESP_OKAY;
         case (r.aw_addr)
            `SEJC_OFF_CTRL: next_r.entry_req = r.entry_req | wr_val[0];
            `SEJC_OFF_SPEED: next_r.speed_set = clamp_spd(wr_val[15:0]);
            `SEJC_OFF_THRESH: next_r.thresh = wr_val[15:0];
            `SEJC_OFF_FUNSEL: begin
               next_r.fun0 = wr_val[7:0];
               next_r.fun1 = wr_val[15:8];
               next_r.fun2 = wr_val[23:16];
               next_r.fun3 = wr_val[31:24];
            end
            `SEJC_OFF_STATUS: next_r.refused = r.refused & ~wr_val[8];
            `SEJC_OFF_CMD: ;
            default: next_r.bresp = `SEJC_RESP_SLVERR;
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
      end

      // Read channel
      if (s_axi_arvalid && !r.rvalid && !r.arready) begin
         next_r.arready = 1'b1;
         next_r.rvalid  = 1'b1;
         next_r.rresp   = `SEJC_RESP_OKAY;
         case (s_axi_araddr)
            `SEJC_OFF_CTRL:   next_r.rdata = 32'h0000_0000;
            `SEJC_OFF_SPEED:  next_r.rdata = {16'h0000, r.speed_set};
            `SEJC_OFF_THRESH: next_r.rdata = {16'h0000, r.thresh};
            `SEJC_OFF_FUNSEL: next_r.rdata = {r.fun3, r.fun2, r.fun1, r.fun0};
            `SEJC_OFF_STATUS: next_r.rdata = {20'h0_0000, r.disp, 1'b0,
                                              r.refused, r.st, r.ready, sv_en};
            `SEJC_OFF_CMD:    next_r.rdata = {12'h000, r.rev, r.fwd, r.brake,
                                              r.power, r.spd};
            default: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = `SEJC_RESP_SLVERR;
            end
         endcase
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end

      next_r.fwd = 1'b0;
      next_r.rev = 1'b0;
      next_r.spd = 16'h0000;
      case (r.st)
         SEJC_RESET: begin
            next_r.disp = SEJC_DISP_BOOT;
            next_r.cnt  = r.cnt + 16'h0001;
            if (r.cnt == `SEJC_RST_CYC) begin
               next_r.st  = SEJC_NRD;
               next_r.cnt = 16'h0000;
            end
         end
         SEJC_NRD: begin
            next_r.disp = SEJC_DISP_NRD;
            next_r.cnt  = r.cnt + 16'h0001;
            if (r.cnt == `SEJC_NRD_CYC) begin
               next_r.st    = SEJC_RDY;
               next_r.ready = 1'b1;
            end
         end
         SEJC_RDY, SEJC_RUN: begin
            next_r.disp = SEJC_DISP_RDY;
            next_r.st   = sv_en ? SEJC_RUN : SEJC_RDY;
            if (r.entry_req) begin
               next_r.entry_req = 1'b0;
               if (sv_en) begin
                  next_r.refused = 1'b1;
               end else begin
                  next_r.st        = SEJC_JMODE;
                  next_r.speed_jog = r.speed_set;
               end
            end
            // Input jog irrespective of control mode
            if (sv_en && jf && !jr) begin
               next_r.fwd = 1'b1;
               next_r.spd = r.speed_set;
            end else if (sv_en && jr && !jf) begin
               next_r.rev = 1'b1;
               next_r.spd = r.speed_set;
            end
         end
         SEJC_JMODE, SEJC_JOG: begin
            next_r.entry_req = 1'b0;
            next_r.disp = (r.st == SEJC_JOG) ? SEJC_DISP_JOG : SEJC_DISP_RDY;
            if (rise_mode || sv_en) begin
               next_r.st = SEJC_RDY;
            end else if (r.st == SEJC_JMODE) begin
               if (rise_up) begin
                  next_r.speed_jog = clamp_spd(r.speed_jog + `SEJC_STEP_MS);
               end else if (rise_dn && r.speed_jog != 16'h0000) begin
                  next_r.speed_jog = r.speed_jog - `SEJC_STEP_MS;
               end else if (rise_set) begin
                  next_r.st = SEJC_JOG;
               end
            end else if (r.s2[4] && !r.s2[5]) begin
               next_r.fwd = 1'b1;
               next_r.spd = r.speed_jog;
            end else if (r.s2[5] && !r.s2[4]) begin
               next_r.rev = 1'b1;
               next_r.spd = r.speed_jog;
            end
         end
         default: next_r.st = SEJC_RESET;
      endcase

      // Power follows enable, or panel jogging
      next_r.power = (next_r.st == SEJC_RUN) || (next_r.st == SEJC_JOG);
      if (next_r.power && !r.power) begin
         next_r.brake = 1'b1;
      end else if (r.power && !next_r.power && motor_speed < r.thresh) begin
         next_r.brake = 1'b0;
      end else if (!next_r.power) begin
         next_r.brake = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r           <= '0;
         r.st        <= SEJC_RESET;
         r.speed_set <= `SEJC_SPEED_DEF;
         r.speed_jog <= `SEJC_SPEED_DEF;
         r.thresh    <= `SEJC_THRESH_DEF;
         r.fun0      <= `SEJC_FUN_ENABLE;
         r.fun1      <= `SEJC_FUN_FWD;
         r.fun2      <= `SEJC_FUN_REV;
      end else begin
         r <= next_r;
      end
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready  = r.wready;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;
   assign motor_power   = r.power;
   assign brake_release = r.brake;
   assign run_fwd       = r.fwd;
   assign run_rev       = r.rev;
   assign speed_cmd     = r.spd;
   assign disp_code     = r.disp;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_boot_order;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_RDY) |-> $past(r.st) != SEJC_RESET;
   endproperty
   a_boot_order: assert property (p_boot_order) else $error("ready before not-ready");

   property p_power_en;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_RUN) |-> r.power;
   endproperty
   a_power_en: assert property (p_power_en) else $error("enable did not power");

   property p_refuse;
      @(posedge aclk) disable iff (!aresetn)
      (r.entry_req && sv_en && r.st == SEJC_RUN) |=> r.refused && r.st != SEJC_JMODE;
   endproperty
   a_refuse: assert property (p_refuse) else $error("jog not refused");

   property p_speed_max;
      @(posedge aclk) disable iff (!aresetn)
      r.speed_set <= `SEJC_SPEED_MAX;
   endproperty
   a_speed_max: assert property (p_speed_max) else $error("speed above range");

   property p_mode_exit;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_JOG && rise_mode) |=> r.st == SEJC_RDY ##1 !r.fwd && !r.rev;
   endproperty
   a_mode_exit: assert property (p_mode_exit) else $error("mode key ignored");

   property p_fwd;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_RUN && sv_en && jf && !jr) |=> r.fwd && r.spd == $past(r.speed_set);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward jog missing");

   property p_rev;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_RUN && sv_en && jr && !jf) |=> r.rev && !r.fwd;
   endproperty
   a_rev: assert property (p_rev) else $error("reverse jog missing");

   property p_both;
      @(posedge aclk) disable iff (!aresetn)
      (r.st == SEJC_RUN && jf && jr) |=> !r.fwd && !r.rev && r.spd == 16'h0000;
   endproperty
   a_both: assert property (p_both) else $error("both jog inputs ran");

   property p_brake;
      @(posedge aclk) disable iff (!aresetn)
      ($fell(r.power)) |-> !r.brake;
   endproperty
   a_brake: assert property (p_brake) else $error("brake held after power off");

   c_ready: cover property (@(posedge aclk) disable iff (!aresetn) r.st == SEJC_RDY);
   c_jog: cover property (@(posedge aclk) disable iff (!aresetn) r.st == SEJC_JOG && r.fwd);
   c_dirun: cover property (@(posedge aclk) disable iff (!aresetn) r.st == SEJC_RUN && r.rev);

endmodule // sejc_top

// ---- sim/sejc_host_model.sv ----
// Host side: digital input wiring and a motor that follows the command.
// Assumes the default function map of di_pins (enable, forward, reverse).
`timescale 1ns/1ns
module sejc_host_model (
   input  wire logic        aclk,
   input  wire logic [2:0]  dio,
   input  wire logic        run_fwd,
   input  wire logic        run_rev,
   input  wire logic [15:0] speed_cmd,
   output logic [3:0]       di_pins,
   output logic [15:0]      motor_speed
);
   // Enable on pin 0, forward on pin 1, reverse on pin 2
   assign di_pins = {1'b0, dio[2], dio[1], dio[0]};
   // Motor stands still unless commanded
   always_ff @(posedge aclk) begin
      motor_speed <= (run_fwd | run_rev) ? speed_cmd : 16'h0000;
   end
endmodule // sejc_host_model

// ---- sim/test_servo_enable_and_jog_control.sv ----
// Self-checking bench for the servo enable and jog control block.
// Assumes registers answer over AXI4-Lite and pins act 3 cycles late.
`timescale 1ns/1ns
`include "sejc_map.svh"
module test_servo_enable_and_jog_control
   import sejc_pkg::*;
();
   logic        aclk;
   logic [3:0]  wstrb;
   logic        aresetn;
   logic [3:0]  di_pins;
   logic [3:0]  keys;
   logic [2:0]  dio;
   logic [15:0] motor_speed;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, rr, br;
   logic        motor_power, brake_release, run_fwd, run_rev;
   logic [15:0] speed_cmd;
   logic [1:0]  disp_code;
   int          miscompares, checks, cyc, n;

   sejc_top dut (.aclk(aclk), .aresetn(aresetn), .di_pins(di_pins), .key_up(keys[0]),
      .key_down(keys[1]), .key_set(keys[2]), .key_mode(keys[3]),
      .motor_speed(motor_speed), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .motor_power(motor_power), .brake_release(brake_release), .run_fwd(run_fwd),
      .run_rev(run_rev), .speed_cmd(speed_cmd), .disp_code(disp_code));

   sejc_host_model host (.aclk(aclk), .dio(dio), .run_fwd(run_fwd), .run_rev(run_rev),
      .speed_cmd(speed_cmd), .di_pins(di_pins), .motor_speed(motor_speed));

   // ****************************************
   // Common tasks
   // ****************************************
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      br = bresp;
      bready <= 1'b0;
   endtask

   task axi_rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask

   task settle;
      repeat (4) @(posedge aclk);
   endtask

   task press(input int k);
      keys[k] <= 1'b1;
      repeat (6) @(posedge aclk);
      keys[k] <= 1'b0;
      repeat (6) @(posedge aclk);
   endtask

   task jog_hold(input int k, input logic [1:0] dir, input logic [15:0] spd);
      keys[k] <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("direction", dir, {run_fwd, run_rev});
      chk("speed_cmd", spd, speed_cmd);
      chk("motor_power", 1'b1, motor_power);
      keys[k] <= 1'b0;
      settle;
      chk("direction", 2'b00, {run_fwd, run_rev});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_power;
      chk("disp", SEJC_DISP_BOOT, disp_code);
      for (n = 0; n < 400 && disp_code !== SEJC_DISP_NRD; n++) @(posedge aclk);
      chk("disp", SEJC_DISP_NRD, disp_code);
      for (n = 0; n < 400 && disp_code !== SEJC_DISP_RDY; n++) @(posedge aclk);
      chk("disp", SEJC_DISP_RDY, disp_code);
      chk("motor_power", 1'b0, motor_power);
      axi_rd(`SEJC_OFF_STATUS);
      chk("ready", 1'b1, rd[1]);
      axi_rd(`SEJC_OFF_SPEED);
      chk("speed", `SEJC_SPEED_DEF, rd);
      axi_rd(`SEJC_OFF_FUNSEL);
      chk("funsel", 32'h0013_1201, rd);
      axi_rd(8'h40);
      chk("rresp", `SEJC_RESP_SLVERR, rr);
      chk("rdata", 32'h0000_0000, rd);
      axi_wr(8'h40, 32'h0000_0000);
      chk("bresp", `SEJC_RESP_SLVERR, br);
      $display("test power done");
   endtask

   task t_panel;
      axi_wr(`SEJC_OFF_CTRL, 32'h0000_0001);
      settle;
      chk("disp", SEJC_DISP_RDY, disp_code);
      press(0);
      press(0);
      press(1);
      press(2);
      chk("disp", SEJC_DISP_JOG, disp_code);
      jog_hold(0, 2'b10, 16'h0065);
      jog_hold(1, 2'b01, 16'h0065);
      press(3);
      chk("disp", SEJC_DISP_RDY, disp_code);
      axi_wr(`SEJC_OFF_CTRL, 32'h0000_0001);
      settle;
      press(2);
      jog_hold(0, 2'b10, `SEJC_SPEED_DEF);
      press(3);
      $display("test panel done");
   endtask

   task t_di;
      dio <= 3'b001;
      settle;
      chk("motor_power", 1'b1, motor_power);
      axi_wr(`SEJC_OFF_SPEED, 32'h0000_1b58);
      chk("bresp", `SEJC_RESP_OKAY, br);
      axi_rd(`SEJC_OFF_SPEED);
      chk("speed", `SEJC_SPEED_MAX, rd);
      wstrb <= 4'h1;
      axi_wr(`SEJC_OFF_SPEED, 32'h0000_1234);
      wstrb <= 4'hf;
      axi_rd(`SEJC_OFF_SPEED);
      chk("speed", 32'h0000_0034, rd);
      axi_wr(`SEJC_OFF_SPEED, 32'h0000_01f4);
      dio <= 3'b011;
      settle;
      chk("direction", 2'b10, {run_fwd, run_rev});
      chk("speed_cmd", 16'h01f4, speed_cmd);
      axi_wr(`SEJC_OFF_SPEED, 32'h0000_0258);
      settle;
      chk("speed_cmd", 16'h0258, speed_cmd);
      dio <= 3'b001;
      settle;
      chk("speed_cmd", 16'h0000, speed_cmd);
      dio <= 3'b101;
      settle;
      chk("direction", 2'b01, {run_fwd, run_rev});
      chk("speed_cmd", 16'h0258, speed_cmd);
      dio <= 3'b111;
      settle;
      chk("direction", 2'b00, {run_fwd, run_rev});
      chk("speed_cmd", 16'h0000, speed_cmd);
      dio <= 3'b001;
      axi_wr(`SEJC_OFF_CTRL, 32'h0000_0001);
      settle;
      chk("disp", SEJC_DISP_RDY, disp_code);
      axi_rd(`SEJC_OFF_STATUS);
      chk("refused", 1'b1, rd[8]);
      axi_wr(`SEJC_OFF_STATUS, 32'h0000_0100);
      axi_rd(`SEJC_OFF_STATUS);
      chk("refused", 1'b0, rd[8]);
      dio <= 3'b000;
      repeat (6) begin
         @(posedge aclk);
         chk("brake", motor_power, brake_release);
      end
      chk("brake", 1'b0, brake_release);
      chk("motor_power", 1'b0, motor_power);
      $display("test di done");
   endtask

   // ****************************************
   // Clock, timeout and main sequence
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      cyc = 0;
      forever begin
         @(posedge aclk);
         cyc++;
         if (cyc == 5000) begin
            miscompares++;
            end_sim;
         end
      end
   end

   initial begin
      miscompares = 0;
      checks = 0;
      aresetn = 1'b0;
      keys = 4'h0;
      wstrb = 4'hf;
      dio = 3'b000;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_power;
      t_panel;
      t_di;
      end_sim;
   end
endmodule // test_servo_enable_and_jog_control
